// ### verilog/cpdc_pkg.sv
package cpdc_pkg;

	// ************************************************************
	// control register field positions
	// ************************************************************
	localparam int unsigned CTRL_W = 32;
	localparam int unsigned BIT_RESET_ALL = 0;
	localparam int unsigned BIT_LDST_OFF = 5;
	localparam int unsigned BIT_USER_OFF = 6;
	localparam int unsigned BIT_USER_LATE = 7;
	localparam int unsigned BIT_FP_OFF = 8;
	localparam int unsigned BIT_FP_COMPLEX_OFF = 9;
	localparam int unsigned BIT_FP_CONVERT_OFF = 10;
	localparam int unsigned BIT_FP_ESTIMATE_OFF = 11;
	localparam int unsigned BIT_FP_SINGLE_OFF = 12;
	localparam int unsigned BIT_FP_DOUBLE_OFF = 13;
	localparam int unsigned BIT_FP_STATUS_OFF = 14;
	localparam int unsigned BIT_FP_LATE = 15;
	localparam int unsigned BIT_STORE_HOLD = 16;
	localparam int unsigned BIT_USER_LDST_PRIV = 17;
	localparam int unsigned BIT_FORCE_ALIGN = 20;
	localparam int unsigned BIT_LITTLE_ORDER_TRAP = 21;
	localparam int unsigned BIT_BIG_ORDER_TRAP = 22;
	localparam int unsigned BIT_COPROC_ON = 31;

	// ************************************************************
	// reset value and implemented-bit mask
	// ************************************************************
	localparam logic [31:0] CTRL_RESET = 32'h0000_0100;
	localparam logic [31:0] CTRL_WRITABLE = 32'h8077_ffe0;

	// ************************************************************
	// execution types and sizes
	// ************************************************************
	localparam logic [1:0] TYPE_EARLY = 2'h0;
	localparam logic [1:0] TYPE_LATE = 2'h1;
	localparam int unsigned ADDR_W = 32;
	localparam int unsigned SIZE_W = 3;

	typedef enum logic {
		ST_IDLE = 1'b0,
		ST_WAIT_WB = 1'b1
	} cpdc_state_e;

	// pre-classified instruction from the pipeline
	typedef struct packed {
		logic valid;
		logic is_fp;
		logic fp_storage;
		logic fp_complex;
		logic fp_convert;
		logic fp_estimate;
		logic fp_single;
		logic fp_double;
		logic fp_status;
		logic is_cop_ldst;
		logic is_user_op;
		logic user_ldst;
		logic is_store;
		logic privileged;
		logic little_order;
		logic [1:0] native_type;
		logic [SIZE_W-1:0] size_log2;
		logic [ADDR_W-1:0] addr;
	} cpdc_instr_s;

	// registered decode result
	typedef struct packed {
		logic valid;
		logic accepted;
		logic illegal_exc;
		logic unimpl_exc;
		logic priv_exc;
		logic align_exc;
		logic order_trap;
		logic [1:0] exec_type;
		logic [ADDR_W-1:0] addr;
	} cpdc_result_s;

	typedef struct packed {
		logic [31:0] ctrl;
		cpdc_state_e st;
		cpdc_result_s res;
		logic permit;
		logic user_clear;
	} cpdc_state_s;

endpackage

// ### verilog/cpdc_ldst_check.sv
`timescale 1ns/1ps
`default_nettype none

// ************************************************************
// address alignment and byte-order trap check
// ************************************************************
module cpdc_ldst_check (
	input wire logic is_ldst,
	input wire logic [cpdc_pkg::ADDR_W-1:0] addr,
	input wire logic [cpdc_pkg::SIZE_W-1:0] size_log2,
	input wire logic little_order,
	input wire logic force_align,
	input wire logic little_trap_en,
	input wire logic big_trap_en,
	output logic [cpdc_pkg::ADDR_W-1:0] addr_out,
	output logic align_exc,
	output logic order_trap
);

	logic [cpdc_pkg::ADDR_W-1:0] low_mask;

	always_comb begin
		low_mask = ~({cpdc_pkg::ADDR_W{1'b1}} << size_log2);
		addr_out = addr;
		if (is_ldst && force_align) begin
			addr_out = addr & ~low_mask;
		end
		align_exc = is_ldst && !force_align && ((addr & low_mask) != '0);
		order_trap = is_ldst && ((little_trap_en && little_order)
			|| (big_trap_en && !little_order));
	end

endmodule

`default_nettype wire

// ### verilog/cpdc_decode_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

// Function
// - control bit 10 stops decode of floating-point convert instructions
// - control bit 11 stops decode of estimate and select instructions
// - control bit 12 stops decode of single-precision-only instructions
// - control bit 13 stops decode of double-precision-only instructions
// - control bit 14 stops decode of fp status/control register moves
// - disabled fp class raises unimplemented exception while fp decode on
// - bit 15 forces non-storage fp instructions to late-confirm type
// - bit 16 delays store commit permit until final writeback passed
// - bit 17 makes user-defined loads and stores privileged only
// - bit 20 forces load/store address down to natural boundary
// - forced alignment suppresses alignment exception
// - bit 21 traps loads/stores with little-endian attribute
// - bit 22 traps loads/stores with big-endian attribute
// - bit 31 set enables interface and decoding per other bits
// - bit 31 clear overrides bits 5,6,8; nothing decoded
// - bit 8 disables all fp decoding; resets to one
// - bit 5 disables coprocessor load/store, bit 6 user ops
// - writing one to bit 0 restores defaults; bit 0 reads zero
module cpdc_decode_ctrl (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic ctrl_wr,
	input wire logic [31:0] ctrl_wdata,
	output logic [31:0] ctrl_rdata,
	output logic user_op_regs_clear,
	input wire cpdc_pkg::cpdc_instr_s instr,
	output logic instr_ready,
	input wire logic final_writeback_stage,
	output cpdc_pkg::cpdc_result_s result,
	output logic commit_permit,
	output logic coproc_interface_on
);

	// ************************************************************
	// reset release
	// ************************************************************
	logic [1:0] rst_sync_q;
	logic rst_n_i;

	// first flop feeds only the second
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end

	assign rst_n_i = rst_sync_q[1];

	// ************************************************************
	// state
	// ************************************************************
	cpdc_pkg::cpdc_state_s s_q;
	cpdc_pkg::cpdc_state_s s_d;
	logic [31:0] c;
	logic take;
	logic is_ldst;
	logic fp_on;
	logic [cpdc_pkg::ADDR_W-1:0] chk_addr;
	logic chk_align;
	logic chk_trap;

	// ************************************************************
	// control bit pick, shared by all decode terms
	// ************************************************************
	function automatic logic ctl(input logic [31:0] r, input int unsigned b);
		ctl = r[b];
	endfunction

	assign c = s_q.ctrl;
	assign take = instr.valid && (s_q.st == cpdc_pkg::ST_IDLE);
	assign is_ldst = instr.is_cop_ldst || (instr.is_fp && instr.fp_storage);
	assign fp_on = ctl(c, cpdc_pkg::BIT_COPROC_ON)
		&& !ctl(c, cpdc_pkg::BIT_FP_OFF);

	// ************************************************************
	// load/store address check
	// ************************************************************
	cpdc_ldst_check u_check (
		.is_ldst(is_ldst),
		.addr(instr.addr),
		.size_log2(instr.size_log2),
		.little_order(instr.little_order),
		.force_align(ctl(c, cpdc_pkg::BIT_FORCE_ALIGN)),
		.little_trap_en(ctl(c, cpdc_pkg::BIT_LITTLE_ORDER_TRAP)),
		.big_trap_en(ctl(c, cpdc_pkg::BIT_BIG_ORDER_TRAP)),
		.addr_out(chk_addr),
		.align_exc(chk_align),
		.order_trap(chk_trap)
	);

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		logic recognised;
		logic unimpl;
		logic ok;
		recognised = 1'b0;
		unimpl = 1'b0;
		ok = 1'b0;
		s_d = s_q;
		s_d.permit = 1'b0;
		s_d.user_clear = 1'b0;
		s_d.res = '0;

		// control register write
		// decode below still sees the old settings this cycle
		if (ctrl_wr) begin
			if (ctrl_wdata[cpdc_pkg::BIT_RESET_ALL]) begin
				s_d.ctrl = cpdc_pkg::CTRL_RESET;
				s_d.user_clear = 1'b1;
			end else begin
				s_d.ctrl = ctrl_wdata & cpdc_pkg::CTRL_WRITABLE;
			end
		end

		// decode of one instruction
		if (take && ctl(c, cpdc_pkg::BIT_COPROC_ON)) begin
			if (instr.is_fp) begin
				recognised = fp_on;
				unimpl = (instr.fp_complex
					&& ctl(c, cpdc_pkg::BIT_FP_COMPLEX_OFF))
					|| (instr.fp_convert
					&& ctl(c, cpdc_pkg::BIT_FP_CONVERT_OFF))
					|| (instr.fp_estimate
					&& ctl(c, cpdc_pkg::BIT_FP_ESTIMATE_OFF))
					|| (instr.fp_single
					&& ctl(c, cpdc_pkg::BIT_FP_SINGLE_OFF))
					|| (instr.fp_double
					&& ctl(c, cpdc_pkg::BIT_FP_DOUBLE_OFF))
					|| (instr.fp_status
					&& ctl(c, cpdc_pkg::BIT_FP_STATUS_OFF));
				unimpl = unimpl && fp_on;
			end else if (instr.is_cop_ldst) begin
				recognised = !ctl(c, cpdc_pkg::BIT_LDST_OFF);
			end else if (instr.is_user_op) begin
				recognised = !ctl(c, cpdc_pkg::BIT_USER_OFF);
			end
		end

		if (take) begin
			s_d.res.valid = 1'b1;
			// interface off: everything falls back to illegal
			s_d.res.illegal_exc = !recognised;
			s_d.res.unimpl_exc = recognised && unimpl;
			s_d.res.priv_exc = recognised && instr.is_user_op
				&& instr.user_ldst && !instr.privileged
				&& ctl(c, cpdc_pkg::BIT_USER_LDST_PRIV);
			s_d.res.align_exc = recognised && chk_align;
			s_d.res.order_trap = recognised && chk_trap;
			s_d.res.addr = chk_addr;
			s_d.res.exec_type = instr.native_type;
			if (instr.is_fp && !instr.fp_storage
				&& ctl(c, cpdc_pkg::BIT_FP_LATE)) begin
				s_d.res.exec_type = cpdc_pkg::TYPE_LATE;
			end
			if (instr.is_user_op && !instr.user_ldst
				&& ctl(c, cpdc_pkg::BIT_USER_LATE)) begin
				s_d.res.exec_type = cpdc_pkg::TYPE_LATE;
			end
			ok = recognised && !s_d.res.unimpl_exc && !s_d.res.priv_exc
				&& !s_d.res.align_exc && !s_d.res.order_trap;
			s_d.res.accepted = ok;
		end

		// commit permit sequencing
		unique case (s_q.st)
			cpdc_pkg::ST_IDLE: begin
				// any accepted store may be held, whatever its class
				if (ok && instr.is_store) begin
					if (ctl(c, cpdc_pkg::BIT_STORE_HOLD)) begin
						s_d.st = cpdc_pkg::ST_WAIT_WB;
					end else begin
						s_d.permit = 1'b1;
					end
				end else if (ok) begin
					s_d.permit = 1'b1;
				end
			end
			cpdc_pkg::ST_WAIT_WB: begin
				// instr_ready stays low until the store retires
				if (final_writeback_stage) begin
					s_d.permit = 1'b1;
					s_d.st = cpdc_pkg::ST_IDLE;
				end
			end
		endcase
	end

	// ************************************************************
	// register update
	// ************************************************************
	always_ff @(posedge clock or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_q.ctrl <= cpdc_pkg::CTRL_RESET;
			s_q.st <= cpdc_pkg::ST_IDLE;
			s_q.res <= '0;
			s_q.permit <= 1'b0;
			s_q.user_clear <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign ctrl_rdata = s_q.ctrl & cpdc_pkg::CTRL_WRITABLE;
	assign user_op_regs_clear = s_q.user_clear;
	assign instr_ready = (s_q.st == cpdc_pkg::ST_IDLE);
	assign result = s_q.res;
	assign commit_permit = s_q.permit;
	assign coproc_interface_on = ctl(c, cpdc_pkg::BIT_COPROC_ON);

endmodule

`default_nettype wire

// ### tb/cpdc_props.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// decode gating checks
// ****
module cpdc_props (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic ctrl_wr,
	input wire logic [31:0] ctrl_wdata,
	input wire logic [31:0] ctrl_rdata,
	input wire logic user_op_regs_clear,
	input wire cpdc_pkg::cpdc_instr_s instr,
	input wire logic instr_ready,
	input wire logic final_writeback_stage,
	input wire cpdc_pkg::cpdc_result_s result,
	input wire logic commit_permit,
	input wire logic coproc_interface_on
);
	logic tk;
	logic ls;
	logic [31:0] c;
	assign c = ctrl_rdata;
	assign tk = instr.valid && instr_ready && !ctrl_wr;
	assign ls = c[31] && ((instr.is_cop_ldst && !c[5])
		|| (instr.is_fp && instr.fp_storage && !c[8]));
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	AST_MASK: assert property ((c & ~cpdc_pkg::CTRL_WRITABLE) == 32'h0)
		else $error("reserved or bit0 reads nonzero");
	AST_WRITE: assert property (ctrl_wr && !ctrl_wdata[0] |=>
		c == ($past(ctrl_wdata) & cpdc_pkg::CTRL_WRITABLE))
		else $error("write value not stored");
	AST_RESET_ALL: assert property (ctrl_wr && ctrl_wdata[0] |=>
		c == cpdc_pkg::CTRL_RESET && user_op_regs_clear)
		else $error("bit0 write did not restore defaults");
	AST_ON: assert property (coproc_interface_on == c[31])
		else $error("interface enable wrong");
	AST_OFF: assert property (tk && !c[31] |=> result.valid && !result.accepted)
		else $error("decoded with interface off");
	AST_FP_OFF: assert property (tk && instr.is_fp && c[8] |=> result.illegal_exc)
		else $error("fp decoded while disabled");
	AST_CONVERT: assert property (tk && instr.is_fp && instr.fp_convert &&
		c[31] && !c[8] && c[10] |=> result.unimpl_exc && !result.accepted)
		else $error("convert not refused");
	AST_LATE: assert property (tk && instr.is_fp && !instr.fp_storage && c[15]
		|=> !result.accepted || result.exec_type == cpdc_pkg::TYPE_LATE)
		else $error("late confirm not forced");
	AST_ALIGN: assert property (tk && ls && c[20] |=> !result.align_exc &&
		(!result.accepted || result.addr == ($past(instr.addr) &
		~((32'h1 << $past(instr.size_log2)) - 32'h1))))
		else $error("forced alignment wrong");
	AST_LTRAP: assert property (tk && ls && instr.little_order && c[21] && c[31]
		|=> result.order_trap)
		else $error("little order trap missing");
	AST_BTRAP: assert property (tk && ls && !instr.little_order && c[22] && c[31]
		|=> result.order_trap)
		else $error("big order trap missing");
	AST_HOLD: assert property (tk && instr.is_store && c[16] |=> !commit_permit)
		else $error("store permit not held");
	AST_RELEASE: assert property (!instr_ready && final_writeback_stage
		|=> commit_permit && instr_ready)
		else $error("held permit not released");
	cover property (tk && c[16] && instr.is_store);
	cover property (tk && c[15] && instr.is_fp);
	cover property (tk && c[20] && ls);
endmodule
`default_nettype wire

// ### tb/cpdc_wb_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// pipeline back end: store passes final writeback after a delay
// ****
module cpdc_wb_model #(parameter int DELAY = 3) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic instr_ready,
	output logic final_writeback_stage
);
	logic [3:0] cnt_q;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 4'h0;
			final_writeback_stage <= 1'b0;
		end else begin
			final_writeback_stage <= !instr_ready && cnt_q == 4'(DELAY);
			if (instr_ready)
				cnt_q <= 4'h0;
			else if (cnt_q <= 4'(DELAY))
				cnt_q <= cnt_q + 4'h1;
		end
	end
endmodule
`default_nettype wire

// ### tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic ctrl_wr = 1'b0;
	logic [31:0] ctrl_wdata = 32'h0;
	logic [31:0] ctrl_rdata;
	logic user_op_regs_clear;
	cpdc_pkg::cpdc_instr_s instr = '0;
	cpdc_pkg::cpdc_instr_s x;
	logic instr_ready;
	logic final_writeback_stage;
	cpdc_pkg::cpdc_result_s result;
	cpdc_pkg::cpdc_result_s res;
	logic commit_permit;
	logic perm;
	logic coproc_interface_on;
	int n_errors = 0;
	int comparisons = 0;
	always #25 clock = ~clock;
	cpdc_decode_ctrl cpdc_decode_ctrl_i (.clock(clock), .rst_n(rst_n),
		.ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata), .ctrl_rdata(ctrl_rdata),
		.user_op_regs_clear(user_op_regs_clear), .instr(instr),
		.instr_ready(instr_ready),
		.final_writeback_stage(final_writeback_stage), .result(result),
		.commit_permit(commit_permit),
		.coproc_interface_on(coproc_interface_on));
	cpdc_wb_model cpdc_wb_model_i (.clock(clock), .rst_n(rst_n),
		.instr_ready(instr_ready),
		.final_writeback_stage(final_writeback_stage));
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			n_errors++;
			$display("BAD %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic wr(input logic [31:0] d);
		@(posedge clock);
		ctrl_wr <= 1'b1;
		ctrl_wdata <= d;
		@(posedge clock);
		ctrl_wr <= 1'b0;
		#1;
	endtask
	task automatic exec(input cpdc_pkg::cpdc_instr_s i);
		@(posedge clock);
		instr <= i;
		@(posedge clock);
		instr.valid <= 1'b0;
		#1;
		res = result;
		perm = commit_permit;
		chk(res.valid, 1'b1);
	endtask
	task automatic wrap_up();
		if (n_errors == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		#100000;
		n_errors++;
		wrap_up();
	end
	initial begin
		repeat (8) @(posedge clock);
		chk(ctrl_rdata, 32'h0000_0100);
		chk(coproc_interface_on, 1'b0);
		rst_n <= 1'b1;
		repeat (3) @(posedge clock);
		x = '0;
		x.valid = 1'b1;
		x.is_fp = 1'b1;
		exec(x);
		chk(res.illegal_exc, 1'b1);
		wr(32'hffff_fffe);
		chk(ctrl_rdata, 32'h8077_ffe0);
		wr(32'h0000_0001);
		chk(user_op_regs_clear, 1'b1);
		chk(ctrl_rdata, 32'h0000_0100);
		wr(32'h8000_0100);
		chk(coproc_interface_on, 1'b1);
		exec(x);
		chk(res.illegal_exc, 1'b1);
		for (int i = 9; i <= 14; i++) begin
			x = '0;
			x.valid = 1'b1;
			x.is_fp = 1'b1;
			case (i)
				9: x.fp_complex = 1'b1;
				10: x.fp_convert = 1'b1;
				11: x.fp_estimate = 1'b1;
				12: x.fp_single = 1'b1;
				13: x.fp_double = 1'b1;
				default: x.fp_status = 1'b1;
			endcase
			wr(32'h8000_0000 | (32'h1 << i));
			exec(x);
			chk({res.unimpl_exc, res.accepted}, 2'b10);
			wr(32'h8000_0000);
			exec(x);
			chk({res.unimpl_exc, res.accepted}, 2'b01);
		end
		x = '0;
		x.valid = 1'b1;
		x.is_fp = 1'b1;
		wr(32'h8000_8000);
		exec(x);
		chk({res.exec_type, perm}, {cpdc_pkg::TYPE_LATE, 1'b1});
		x = '0;
		x.valid = 1'b1;
		x.is_cop_ldst = 1'b1;
		x.size_log2 = 3'h3;
		x.addr = 32'h0000_1007;
		wr(32'h8010_0000);
		exec(x);
		chk(res.align_exc, 1'b0);
		chk(res.addr, 32'h0000_1000);
		chk(res.accepted, 1'b1);
		wr(32'h8000_0020);
		exec(x);
		chk(res.illegal_exc, 1'b1);
		x.little_order = 1'b1;
		wr(32'h8020_0000);
		exec(x);
		chk(res.order_trap, 1'b1);
		chk(res.align_exc, 1'b1);
		x.little_order = 1'b0;
		wr(32'h8040_0000);
		exec(x);
		chk(res.order_trap, 1'b1);
		x = '0;
		x.valid = 1'b1;
		x.is_user_op = 1'b1;
		x.user_ldst = 1'b1;
		wr(32'h8002_0000);
		exec(x);
		chk(res.priv_exc, 1'b1);
		x.user_ldst = 1'b0;
		wr(32'h8000_0080);
		exec(x);
		chk(res.exec_type, cpdc_pkg::TYPE_LATE);
		x = '0;
		x.valid = 1'b1;
		x.is_cop_ldst = 1'b1;
		x.is_store = 1'b1;
		wr(32'h8001_0000);
		exec(x);
		chk({perm, instr_ready}, 2'b00);
		for (int k = 0; k < 20 && commit_permit !== 1'b1; k++)
			@(posedge clock) #1;
		chk({commit_permit, instr_ready}, 2'b11);
		@(posedge clock);
		rst_n <= 1'b0;
		@(posedge clock) #1;
		chk(ctrl_rdata, 32'h0000_0100);
		chk(coproc_interface_on, 1'b0);
		chk(instr_ready, 1'b1);
		@(posedge clock);
		rst_n <= 1'b1;
		repeat (3) @(posedge clock);
		exec(x);
		chk(res.illegal_exc, 1'b1);
		wrap_up();
	end
endmodule
bind cpdc_decode_ctrl cpdc_props cpdc_props_i (.clock(clock), .rst_n(rst_n),
	.ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata), .ctrl_rdata(ctrl_rdata),
	.user_op_regs_clear(user_op_regs_clear), .instr(instr),
	.instr_ready(instr_ready), .final_writeback_stage(final_writeback_stage),
	.result(result), .commit_permit(commit_permit),
	.coproc_interface_on(coproc_interface_on));
`default_nettype wire
